// ===== csg_core.sv
/*
 * CPU status word and software stack guard: flags, priority level,
 * stack pointer, stack limit checks and protected RAM gating.
 * Assumes one clock pclk, asynchronous active-low presetn, an APB master
 * and the core's execution unit on the plain ports.
 */
// Implementation choices: the APB slave port and the placing of the registers.
// Behaviour
// (R1) Status bits 15..9 read zero
// (R2) Half carry from bit 4 or 8
// (R3) Bits 7..5 hold priority level
// (R4) Extension bit forms levels 8..15
// (R5) Nesting disable makes level read-only
// (R6) Bit 4 mirrors repeat loop, read-only
// (R7) Negative flag follows result sign
// (R8) Overflow flag marks signed wrap
// (R9) Zero flag clears on non-zero, sticky; the code also sets it on a zero result
// (R10) Carry flag from top bit carry
// (R11) Stack pointer points to free word, grows up
// (R12) Push post-increments, pop pre-decrements
// (R13) Call push zero-extends PC upper byte
// (R14) Exception push puts status low byte above
// (R15) Stack limit not reset
// (R16) Stack limit bit 0 forced zero
// (R17) Stack pointer addresses checked against limit
// (R18) Push at limit ok, next traps
// (R19) Address below 0x0800 traps underflow
// (R20) No indirect stack read right after limit write
// (R21) Boot RAM only from boot code
// (R22) Secure RAM only from secure code
// (R23) Overflow is carry-in xor carry-out
// (R24) Stack error is one pending trap
`timescale 1ns/1ps
module csg_core #(
  parameter logic [15:0] BOOT_RAM_LO = 16'h0800,
  parameter logic [15:0] BOOT_RAM_HI = 16'h0fff,
  parameter logic [15:0] SEC_RAM_LO  = 16'h1000,
  parameter logic [15:0] SEC_RAM_HI  = 16'h17ff
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire csg_pkg::csg_alu_t alu,
  input  wire logic              repeat_busy,
  input  wire csg_pkg::csg_stk_t stk,
  input  wire logic [7:0]        pc_upper,
  input  wire logic              ram_req,
  input  wire logic [15:0]       ram_addr,
  input  wire logic              code_in_boot,
  input  wire logic              code_in_secure,
  input  wire logic              trap_ack,
  output logic                   stack_trap,
  output logic                   ram_deny,
  output logic                   push_valid,
  output logic      [15:0]       push_addr,
  output logic      [15:0]       push_data,
  output logic      [15:0]       pop_addr,
  output logic                   pop_valid,
  output logic      [3:0]        cpu_level,
  output logic                   user_irq_off
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [8:0]  flags_ff;        // DC, IPL, -, N, OV, Z, C (bit 4 unused).
  logic [15:0] sp_ff;
  logic [15:0] limit_ff;
  logic [15:0] corectl_ff;
  logic [15:0] intctl1_ff;
  logic [1:0]  prot_ff;
  logic [1:0]  trapst_ff;
  logic [8:0]  nxt_flags;
  logic [15:0] nxt_sp;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Writes land only at the completing edge, so a write-one-to-clear
  // acts once and cannot wipe an event set in the completing cycle itself.
  wire wr_en  = psel & penable & pwrite & pready;
  wire hit_st = (paddr == csg_pkg::OFS_STATUS);
  wire hit_sp = (paddr == csg_pkg::OFS_SPTR);
  wire hit_lm = (paddr == csg_pkg::OFS_SLIMIT);
  wire hit_cc = (paddr == csg_pkg::OFS_CORECTL);
  wire hit_i1 = (paddr == csg_pkg::OFS_INTCTL1);
  wire hit_pr = (paddr == csg_pkg::OFS_PROTECT);
  wire hit_ts = (paddr == csg_pkg::OFS_TRAPSTAT);
  wire mapped = hit_st | hit_sp | hit_lm | hit_cc | hit_i1 | hit_pr
              | hit_ts;
  wire nest_dis = intctl1_ff[csg_pkg::INT1_NEST_POS];
  wire ipl3     = corectl_ff[csg_pkg::CORE_IPL3_POS];

  // (R1) Upper bits read zero.
  // (R6) Loop flag is the live input.
  wire [15:0] status_rd = {7'h00, flags_ff[8:5], repeat_busy,
                           flags_ff[3:0]};
  wire [15:0] rd_mux =
      hit_st ? status_rd  : hit_sp ? sp_ff : hit_lm ? limit_ff :
      hit_cc ? corectl_ff : hit_i1 ? intctl1_ff :
      hit_pr ? {14'h0000, prot_ff} :
      hit_ts ? {14'h0000, trapst_ff} : 16'h0000;

  // ****************************************************************
  // Flag update from the ALU
  // ****************************************************************
  wire msb_r   = alu.is_byte ? alu.result[7] : alu.result[15];
  wire zero_r  = alu.is_byte ? (alu.result[7:0] == 8'h00)
                             : (alu.result == 16'h0000);

  // Software writes act first, the ALU result of the same cycle wins.
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_en && hit_st) begin
      nxt_flags[8] = pwdata[csg_pkg::STS_DC];
      nxt_flags[3:0] = pwdata[3:0];
      // (R5) Level locked while nesting off.
      if (!nest_dis) begin
        nxt_flags[7:5] = pwdata[7:5];
      end
    end
    if (alu.valid) begin
      // (R2) Half carry.
      nxt_flags[8] = alu.c_half;
      // (R7) Negative from sign.
      nxt_flags[csg_pkg::STS_N] = msb_r;
      // (R8) (R23) Overflow as carry xor.
      nxt_flags[csg_pkg::STS_OV] = alu.c_into ^ alu.c_msb;
      // (R9) Zero clears on non-zero, sets on zero.
      if (!zero_r) begin
        nxt_flags[csg_pkg::STS_Z] = 1'b0;
      end else begin
        nxt_flags[csg_pkg::STS_Z] = 1'b1;
      end
      // (R10) Carry out of top bit.
      nxt_flags[csg_pkg::STS_C] = alu.c_msb;
    end
    nxt_flags[4] = 1'b0;
  end

  // ****************************************************************
  // Stack pointer and guard
  // ****************************************************************
  wire is_push = (stk.kind == csg_pkg::SK_PUSH);
  wire is_pop  = (stk.kind == csg_pkg::SK_POP);
  wire is_ea   = (stk.kind == csg_pkg::SK_EA);
  wire [15:0] pop_ea = sp_ff - 16'h0002;
  // (R17) Checked address for each kind.
  wire [15:0] chk_ea = is_push ? sp_ff : is_pop ? pop_ea : stk.ea;
  wire        chk_on = is_push | is_pop | is_ea;
  // (R18) Equal to limit is allowed.
  wire over  = chk_on && (chk_ea > limit_ff);
  // (R19) Below floor is underflow.
  wire under = chk_on && (chk_ea < csg_pkg::STACK_FLOOR);
  // (R13) (R14) Upper PC word content.
  wire [15:0] push_word =
      stk.pc_exc  ? {status_rd[7:0], pc_upper} :
      stk.pc_call ? {8'h00, pc_upper} : stk.wdata;

  // (R11) (R12) Push post-increment, pop pre-decrement.
  always_comb begin
    nxt_sp = sp_ff;
    if (wr_en && hit_sp) begin
      nxt_sp = {pwdata[15:1], 1'b0};
    end
    if (is_push) begin
      nxt_sp = sp_ff + 16'h0002;
    end else if (is_pop) begin
      nxt_sp = pop_ea;
    end
  end

  // ****************************************************************
  // RAM protection
  // ****************************************************************
  // (R21) Boot segment gate.
  wire boot_bad = prot_ff[csg_pkg::PROT_BOOT_POS] && !code_in_boot &&
                  ram_addr >= BOOT_RAM_LO && ram_addr <= BOOT_RAM_HI;
  // (R22) Secure segment gate.
  wire sec_bad  = prot_ff[csg_pkg::PROT_SEC_POS] && !code_in_secure &&
                  ram_addr >= SEC_RAM_LO && ram_addr <= SEC_RAM_HI;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Control and status flops with reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff   <= 9'h000;
      sp_ff      <= csg_pkg::SPTR_RST;
      corectl_ff <= 16'h0000;
      intctl1_ff <= 16'h0000;
      prot_ff    <= 2'h0;
    end else begin
      flags_ff <= nxt_flags;
      sp_ff    <= nxt_sp;
      if (wr_en && hit_cc) begin
        corectl_ff <= pwdata[15:0];
      end
      if (wr_en && hit_i1) begin
        intctl1_ff <= pwdata[15:0];
      end
      if (wr_en && hit_pr) begin
        prot_ff <= pwdata[1:0];
      end
    end
  end

  // (R15) (R16) Limit has no reset; bit 0 is always zero.
  always_ff @(posedge pclk) begin
    if (wr_en && hit_lm) begin
      limit_ff <= {pwdata[15:1], 1'b0};
    end
  end

  // (R24) One pending trap; set wins over acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_trap <= 1'b0;
      trapst_ff  <= 2'h0;
    end else begin
      if (over | under) begin
        stack_trap <= 1'b1;
      end else if (trap_ack) begin
        stack_trap <= 1'b0;
      end
      trapst_ff <= (trapst_ff & ~((wr_en && hit_ts) ? pwdata[1:0] : 2'h0))
                 | {under, over};
    end
  end

  // Registered outputs toward the core and the APB master.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      ram_deny     <= 1'b0;
      push_valid   <= 1'b0;
      push_addr    <= 16'h0000;
      push_data    <= 16'h0000;
      pop_valid    <= 1'b0;
      pop_addr     <= 16'h0000;
      cpu_level    <= 4'h0;
      user_irq_off <= 1'b0;
    end else begin
      // One wait state: pready rises in the second access cycle.
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= {16'h0000, rd_mux};
      ram_deny <= ram_req & (boot_bad | sec_bad);
      // The access completes even when it traps.
      push_valid <= is_push;
      push_addr  <= sp_ff;
      push_data  <= push_word;
      pop_valid  <= is_pop;
      pop_addr   <= pop_ea;
      // (R3) (R4) Effective level.
      cpu_level    <= {ipl3, nxt_flags[7:5]};
      user_irq_off <= ipl3 | (nxt_flags[7:5] == 3'h7);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // All checks rest while reset is low, so the first edges after the
  // release only see values that reset has defined.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // (R1) Upper bits read zero.
  status_top_a: assert property ( // (R1)
    psel && penable && pready && hit_st |-> prdata[31:9] == 23'h0)
    else $error("status upper bits not zero");

  // (R6) Loop flag read live.
  loop_flag_a: assert property ( // (R6)
    psel && penable && pready && hit_st |->
      prdata[4] == $past(repeat_busy))
    else $error("loop flag not live");

  // (R2) Half carry capture.
  half_carry_a: assert property ( // (R2)
    alu.valid |=> flags_ff[8] == $past(alu.c_half))
    else $error("half carry wrong");

  // (R7) Negative from sign.
  neg_flag_a: assert property ( // (R7)
    alu.valid |=> flags_ff[3] ==
      $past(alu.is_byte ? alu.result[7] : alu.result[15]))
    else $error("negative flag wrong");

  // (R9) Zero flag update.
  zero_flag_a: assert property ( // (R9)
    alu.valid |=> flags_ff[1] == $past(alu.is_byte ?
      alu.result[7:0] == 8'h00 : alu.result == 16'h0000))
    else $error("zero flag wrong");

  // (R10) Carry out capture.
  carry_flag_a: assert property ( // (R10)
    alu.valid |=> flags_ff[0] == $past(alu.c_msb))
    else $error("carry flag wrong");

  // (R8) (R23) Overflow as carry xor.
  ovf_xor_a: assert property ( // (R8) (R23)
    alu.valid |=> flags_ff[2] == ($past(alu.c_into) ^ $past(alu.c_msb)))
    else $error("overflow not carry xor");

  // (R5) Level locked while nesting off.
  level_lock_a: assert property ( // (R5)
    nest_dis && !alu.valid |=> $stable(flags_ff[7:5]))
    else $error("level changed while locked");

  // (R4) Effective level output.
  level_out_a: assert property ( // (R4)
    1'b1 |=> cpu_level == {$past(ipl3), flags_ff[7:5]})
    else $error("effective level mismatch");
  // (R3) (R4) User interrupt mask.
  irq_off_a: assert property ( // (R3)
    1'b1 |=> user_irq_off == ($past(ipl3) || flags_ff[7:5] == 3'h7))
    else $error("user interrupt mask wrong");

  // (R12) Push post-increment.
  push_step_a: assert property ( // (R12)
    is_push |=> sp_ff == $past(sp_ff) + 16'h0002)
    else $error("push did not increment");
  // (R12) Pop pre-decrement.
  pop_step_a: assert property ( // (R12)
    is_pop |=> pop_valid && pop_addr == sp_ff &&
      sp_ff == $past(sp_ff) - 16'h0002)
    else $error("pop did not pre-decrement");

  // (R16) Limit word aligned.
  limit_even_a: assert property ( // (R16)
    wr_en && hit_lm |=> limit_ff[0] == 1'b0)
    else $error("limit bit zero set");

  // (R18) Beyond limit traps.
  over_trap_a: assert property ( // (R18)
    over |=> stack_trap)
    else $error("overflow not trapped");
  // (R19) Below floor traps.
  under_trap_a: assert property ( // (R19)
    under |=> stack_trap)
    else $error("underflow not trapped");
  // (R24) Trap held until acknowledged.
  trap_hold_a: assert property ( // (R24)
    stack_trap && !trap_ack |=> stack_trap)
    else $error("trap dropped without acknowledge");

  // (R13) Call push zero byte.
  call_zero_a: assert property ( // (R13)
    is_push && stk.pc_call && !stk.pc_exc |=> push_data[15:8] == 8'h00)
    else $error("call push upper byte not zero");
  // (R14) Exception push status byte.
  exc_word_a: assert property ( // (R14)
    is_push && stk.pc_exc |=> push_data[15:8] ==
      {$past(flags_ff[7:5]), $past(repeat_busy), $past(flags_ff[3:0])})
    else $error("exception push upper byte wrong");

  // (R21) Boot segment denied.
  boot_gate_a: assert property ( // (R21)
    ram_req && boot_bad |=> ram_deny)
    else $error("boot RAM not denied");
  // (R22) Secure segment denied.
  sec_gate_a: assert property ( // (R22)
    ram_req && sec_bad |=> ram_deny)
    else $error("secure RAM not denied");

  // Main scenarios: pushes in a row, both traps, exception push, APB.
  push_cov:  cover property (is_push ##1 is_push);
  trap_cov:  cover property (over ##1 stack_trap);
  under_cov: cover property (under ##1 stack_trap);
  exc_cov:   cover property (is_push && stk.pc_exc);
  apb_cov:   cover property (psel && penable && pready);

endmodule : csg_core

// ===== csg_exec_model.sv
/*
 * Execution-side model for csg_core: issues ALU flag results, stack
 * operations and the repeat-loop level, one operation per call.
 * Assumes the bench calls its tasks only after reset is released.
 */
`timescale 1ns/1ps
// ****************************************************************
// Execution unit model
// ****************************************************************
module csg_exec_model (
  input  wire logic         pclk,
  output csg_pkg::csg_alu_t alu,
  output csg_pkg::csg_stk_t stk,
  output logic [7:0]        pc_upper,
  output logic              repeat_busy
);
  // The upper counter bits stay fixed; that is enough to tell apart
  // the call form and the exception form of a counter push.
  initial begin
    alu = '0;
    stk = {csg_pkg::SK_IDLE, 34'h0};
    pc_upper = 8'ha5;
    repeat_busy = 1'b0;
  end

  // One ALU completion, valid for a single cycle.
  task alu_op(input csg_pkg::csg_alu_t a);
    @(posedge pclk);
    alu <= a;
    @(posedge pclk);
    alu.valid <= 1'b0;
  endtask : alu_op

  // Spaced stack access.
  // One stack operation for one cycle. Callers never issue one right
  // after a limit write, because the bench reads the limit back first.
  task stk_op(input csg_pkg::csg_stk_t s);
    @(posedge pclk);
    stk <= s;
    @(posedge pclk);
    stk.kind <= csg_pkg::SK_IDLE;
  endtask : stk_op

  // Repeat loop level as the sequencer would hold it.
  task set_loop(input logic b);
    @(posedge pclk);
    repeat_busy <= b;
  endtask : set_loop
endmodule : csg_exec_model

// ===== csg_pkg.sv
/*
 * Package for the CPU status word and stack guard block.
 * Holds register offsets, field positions, reset values, bounds and the
 * packed structs that carry ALU results and stack accesses.
 * Assumes nothing of its surroundings.
 */
package csg_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_SPTR     = 8'h04;
  localparam logic [7:0] OFS_SLIMIT   = 8'h08;
  localparam logic [7:0] OFS_CORECTL  = 8'h0c;
  localparam logic [7:0] OFS_INTCTL1  = 8'h10;
  localparam logic [7:0] OFS_PROTECT  = 8'h14;
  localparam logic [7:0] OFS_TRAPSTAT = 8'h18;

  // ****************************************************************
  // Status word and control register fields, reset values and bounds
  // ****************************************************************
  localparam int STS_C    = 0;
  localparam int STS_Z    = 1;
  localparam int STS_OV   = 2;
  localparam int STS_N    = 3;
  localparam int STS_RA   = 4;
  localparam int STS_IPL  = 5;
  localparam int STS_DC   = 8;
  localparam int CORE_IPL3_POS  = 3;
  localparam int INT1_NEST_POS  = 15;
  localparam int PROT_BOOT_POS  = 0;
  localparam int PROT_SEC_POS   = 1;
  localparam int TRAP_OVER_POS  = 0;
  localparam int TRAP_UNDER_POS = 1;

  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] SPTR_RST    = 16'h0800;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid;    // Flag-affecting operation completes.
    logic        is_byte;  // Byte operand when high, word when low.
    logic [15:0] result;
    logic        c_msb;    // Carry out of the operand's top bit.
    logic        c_into;   // Carry into the operand's top bit.
    logic        c_half;   // Carry out of bit 4 (byte) or bit 8 (word).
  } csg_alu_t;

  typedef enum logic [3:0] {
    SK_IDLE = 4'b0001,
    SK_PUSH = 4'b0010,
    SK_POP  = 4'b0100,
    SK_EA   = 4'b1000
  } csg_sk_t;

  typedef struct packed {
    csg_sk_t     kind;
    logic [15:0] ea;       // Effective address for SK_EA.
    logic [15:0] wdata;    // Word to push.
    logic        pc_call;  // Word is upper PC word of a call.
    logic        pc_exc;   // Word is upper PC word of an exception.
  } csg_stk_t;

endpackage : csg_pkg

// ===== tb_top.sv
/*
 * Self-checking bench for csg_core: APB register tasks, ALU and stack
 * sequences through csg_exec_model, and RAM protection checks.
 * Assumes csg_pkg, csg_core and csg_exec_model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
  logic              pclk, presetn, psel, penable, pwrite, er;
  logic [7:0]        paddr, pc_upper;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, trap_ack, ram_req, ram_deny;
  logic              code_in_boot, code_in_secure, stack_trap;
  logic [15:0]       ram_addr, push_addr, push_data, pop_addr;
  logic              push_valid, pop_valid, user_irq_off, repeat_busy;
  logic [3:0]        cpu_level;
  csg_pkg::csg_alu_t alu;
  csg_pkg::csg_stk_t stk;
  int                errors, checks_done;

  csg_core u_csg_core (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .alu, .repeat_busy,
    .stk, .pc_upper, .ram_req, .ram_addr, .code_in_boot,
    .code_in_secure, .trap_ack, .stack_trap, .ram_deny, .push_valid,
    .push_addr, .push_data, .pop_addr, .pop_valid, .cpu_level,
    .user_irq_off);
  csg_exec_model u_csg_exec_model (.pclk, .alu, .stk, .pc_upper,
    .repeat_busy);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk

  // Flags are worked out from the operand fields, not from the design.
  task aop(input logic b, input logic [15:0] r, input logic cm, ci, ch);
    logic n, z;
    n = b ? r[7] : r[15];
    z = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
    u_csg_exec_model.alu_op({1'b1, b, r, cm, ci, ch});
    rdchk("flags", csg_pkg::OFS_STATUS,
          {23'h0, ch, 4'h0, n, cm ^ ci, z, cm});
  endtask : aop

  // Stack operation; v is the pushed word or the checked address.
  task sop(input csg_pkg::csg_sk_t k, input logic [15:0] v,
           input logic [1:0] pc, input logic [15:0] a, d,
           input logic t);
    u_csg_exec_model.stk_op({k, v, v, pc});
    #1;
    if (k == csg_pkg::SK_PUSH) begin
      chk("push_addr", {push_valid, push_addr}, {1'b1, a});
      chk("push_data", push_data, d);
    end
    if (k == csg_pkg::SK_POP) begin
      chk("pop_addr", {pop_valid, pop_addr}, {1'b1, a});
    end
    chk("stack_trap", stack_trap, t);
  endtask : sop

  // Acknowledge the pending trap, then clear both status bits.
  task ack;
    @(posedge pclk);
    trap_ack <= 1'b1;
    @(posedge pclk);
    trap_ack <= 1'b0;
    #1;
    chk("trap_clear", stack_trap, 1'b0);
    apb(1'b1, csg_pkg::OFS_TRAPSTAT, 32'h3);
  endtask : ack

  task ram(input logic [15:0] a, input logic b, s, e);
    @(posedge pclk);
    ram_req <= 1'b1;
    ram_addr <= a;
    code_in_boot <= b;
    code_in_secure <= s;
    @(posedge pclk);
    ram_req <= 1'b0;
    #1;
    chk("ram_deny", ram_deny, e);
  endtask : ram

  task give_verdict;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // The whole sequence takes well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, trap_ack, ram_req} = 6'h0;
    {code_in_boot, code_in_secure, paddr, pwdata, ram_addr} = '0;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", csg_pkg::OFS_STATUS, 32'h0);
    rdchk("sptr", csg_pkg::OFS_SPTR, 32'h0800);
    apb(1'b1, 8'h1c, 32'h1);
    chk("slverr", er, 1'b1);
    apb(1'b1, csg_pkg::OFS_STATUS, 32'hffff);
    rdchk("status", csg_pkg::OFS_STATUS, 32'h01ef);
    @(posedge pclk);
    #1;
    chk("level", {user_irq_off, cpu_level}, 5'h17);
    u_csg_exec_model.set_loop(1'b1);
    rdchk("status", csg_pkg::OFS_STATUS, 32'h01ff);
    u_csg_exec_model.set_loop(1'b0);
    apb(1'b1, csg_pkg::OFS_INTCTL1, 32'h8000);
    apb(1'b1, csg_pkg::OFS_STATUS, 32'h0);
    rdchk("status", csg_pkg::OFS_STATUS, 32'h00e0);
    apb(1'b1, csg_pkg::OFS_INTCTL1, 32'h0);
    apb(1'b1, csg_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, csg_pkg::OFS_CORECTL, 32'h8);
    @(posedge pclk);
    #1;
    chk("level", {user_irq_off, cpu_level}, 5'h18);
    apb(1'b1, csg_pkg::OFS_CORECTL, 32'h0);
    aop(1'b0, 16'h8000, 1'b1, 1'b0, 1'b0);
    aop(1'b1, 16'h0100, 1'b0, 1'b1, 1'b1);
    aop(1'b0, 16'h0001, 1'b1, 1'b1, 1'b1);
    // to Stack walk against the limit.
    apb(1'b1, csg_pkg::OFS_STATUS, 32'h000f);
    apb(1'b1, csg_pkg::OFS_SLIMIT, 32'h0803);
    rdchk("limit", csg_pkg::OFS_SLIMIT, 32'h0802);
    sop(csg_pkg::SK_PUSH, 16'h1234, 2'b00, 16'h0800, 16'h1234, 1'b0);
    sop(csg_pkg::SK_PUSH, 16'h1234, 2'b10, 16'h0802, 16'h00a5, 1'b0);
    sop(csg_pkg::SK_PUSH, 16'h1234, 2'b01, 16'h0804, 16'h0fa5, 1'b1);
    rdchk("trapstat", csg_pkg::OFS_TRAPSTAT, 32'h1);
    ack();
    sop(csg_pkg::SK_POP, 16'h0, 2'b00, 16'h0804, 16'h0, 1'b1);
    ack();
    sop(csg_pkg::SK_POP, 16'h0, 2'b00, 16'h0802, 16'h0, 1'b0);
    apb(1'b1, csg_pkg::OFS_SPTR, 32'h0800);
    sop(csg_pkg::SK_POP, 16'h0, 2'b00, 16'h07fe, 16'h0, 1'b1);
    rdchk("trapstat", csg_pkg::OFS_TRAPSTAT, 32'h2);
    ack();
    sop(csg_pkg::SK_EA, 16'h0802, 2'b00, 16'h0, 16'h0, 1'b0);
    sop(csg_pkg::SK_EA, 16'h0a00, 2'b00, 16'h0, 16'h0, 1'b1);
    ack();
    apb(1'b1, csg_pkg::OFS_PROTECT, 32'h3);
    ram(16'h0900, 1'b0, 1'b0, 1'b1);
    ram(16'h0900, 1'b1, 1'b0, 1'b0);
    ram(16'h1100, 1'b1, 1'b0, 1'b1);
    ram(16'h1100, 1'b0, 1'b1, 1'b0);
    apb(1'b1, csg_pkg::OFS_PROTECT, 32'h0);
    ram(16'h0900, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : tb_top
